// >>> hw/serial_port_pkg.sv
package serial_port_pkg;

  // Register word and address types of the byte-wide register port
  typedef logic [7:0] byte_t;
  typedef logic [7:0] addr_t;

  // Register addresses
  localparam addr_t CTRL_ADDR = 8'h98;
  localparam addr_t DATA_ADDR = 8'h99;
  localparam addr_t RATE_ADDR = 8'h9A;
  localparam byte_t RESET_BYTE = 8'h00;
  localparam logic RESET_BIT = 1'b0;

  // Mode select encodings, high bit first
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_UART8 = 2'h1;
  localparam logic [1:0] MODE_UART9_FIXED = 2'h2;
  localparam logic [1:0] MODE_UART9_VAR = 2'h3;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic mode_select_high;
    logic mode_select_low;
    logic multiprocessor_enable;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } port_ctrl_t;

  // Bit rate: async links are sampled at sixteen ticks per bit
  localparam int OVERSAMPLE = 16;
  localparam int MODE2_DIV = 64;
  localparam int MODE2_DIV_FAST = 32;
  localparam int MODE0_DIV = 2;
  localparam logic [1:0] M2_TICK_SLOW = 2'(MODE2_DIV / OVERSAMPLE - 1);
  localparam logic [1:0] M2_TICK_FAST = 2'(MODE2_DIV_FAST / OVERSAMPLE - 1);
  localparam logic M0_PHASE_LAST = 1'(MODE0_DIV - 1);
  localparam logic [3:0] OS_LAST = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] OS_MID = 4'(OVERSAMPLE / 2 - 1);

  // Frame lengths and bit positions
  localparam logic [3:0] FRAME_EIGHT = 4'hA;
  localparam logic [3:0] FRAME_NINE = 4'hB;
  localparam logic [3:0] TX_STOP_NEXT = 4'h2;
  localparam logic [3:0] TX_BIT_LAST = 4'h1;
  localparam logic [3:0] RX_LAST_EIGHT = 4'h8;
  localparam logic [3:0] RX_LAST_NINE = 4'h9;
  localparam logic [3:0] M0_BIT_LAST = 4'h7;
  localparam logic START_BIT = 1'b0;
  localparam logic STOP_BIT = 1'b1;
  localparam logic IDLE_LINE = 1'b1;

  typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_WAIT = 3'b010, TX_SHIFT = 3'b100} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_START = 3'b010, RX_BITS = 3'b100} rx_state_t;
  typedef enum logic [2:0] {SY_IDLE = 3'b001, SY_TX = 3'b010, SY_RX = 3'b100} sy_state_t;

endpackage

// >>> hw/serial_port.sv
// Notes on behaviour
// - Two mode-select bits pick shift, 8-bit, fixed 9-bit or variable 9-bit mode.
// - Receptions start only while receive-enable is set; clearing it blocks new ones.
// - Modes 2 and 3 send the transmit ninth bit as ninth data bit.
// - Received ninth bit, or stop bit in mode 1, goes to receive ninth field.
// - Transmit-done sets after eighth bit in mode 0, at stop start otherwise.
// - Receive-done sets after eighth bit in mode 0, mid stop otherwise; software clears.
// - A data register write starts a transmission; in mode 0 only while the shift engine is idle.
// - Mode 0 shifts eight bits LSB first on receive pin, clock on transmit pin.
// - Mode 0 receives when receive-enable is 1 and receive-done is 0.
// - Mode 1 frame: start 0, eight data bits LSB first, stop 1.
// - Mode 1 write loads stop bit at ninth shifter position, then shifts out.
// - Mode 1 reception starts on falling receive pin, skips start, takes eight bits.
// - After the last bit, received byte goes to receive register, receive-done sets.
// - Frame kept only if receive-done is 0 and stop is 1 at final shift.
// - Mode 2 runs at core clock over 64, or over 32 with rate doubling.
// - Mode 2 frame: start 0, eight data bits, ninth bit, stop 1.
// - Mode 2 send loads data then ninth bit, starts at next rate tick.
// - Modes 1 and 3 take separate transmit and receive timer tick inputs.
// - Mode 3 frames match mode 2 but use the timer rate.
// - Async modes start receiving on a start bit only while receive-enable is 1.
// - Multiprocessor enable in 9-bit modes drops frames whose ninth bit is 0.
// - Data writes go to transmit side; reads return a separate receive register.
`timescale 1ns/1ps
`default_nettype none

module serial_port (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire serial_port_pkg::addr_t reg_addr,
  input wire serial_port_pkg::byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output var serial_port_pkg::byte_t reg_rdata,
  input wire logic tx_ovf_tick,
  input wire logic rx_ovf_tick,
  input wire logic rxd_in,
  output var logic rxd_out,
  output var logic rxd_oe,
  output var logic txd_out
);
  import serial_port_pkg::*;

  port_ctrl_t ctrl_reg, ctrl_next;
  byte_t rx_buf_reg, rdata_reg;
  logic rate_double_reg, nine_bit;
  logic [1:0] mode;
  logic wr_data, wr_ctrl, wr_rate;
  logic [1:0] m2_div_reg;
  logic m2_tick, tx_tick, rx_tick;
  tx_state_t tx_state;
  logic [10:0] tx_shift_reg;
  logic [3:0] tx_left_reg, tx_os_reg;
  logic tx_ti_set;
  sy_state_t sy_state;
  byte_t sy_shift_reg, sy_frame;
  logic [3:0] sy_cnt_reg;
  logic sy_phase_reg, sy_done;
  rx_state_t rx_state;
  logic [9:0] rx_shift_reg, rx_frame;
  logic [3:0] rx_os_reg, rx_cnt_reg;
  logic rx_prev_reg, rx_final, rx_ninth, rx_accept;
  byte_t rx_data;
  assign mode = {ctrl_reg.mode_select_high, ctrl_reg.mode_select_low};
  assign nine_bit = ctrl_reg.mode_select_high;
  // Address decode of the write strobe
  assign wr_data = reg_wr && (reg_addr == DATA_ADDR);
  assign wr_ctrl = reg_wr && (reg_addr == CTRL_ADDR);
  assign wr_rate = reg_wr && (reg_addr == RATE_ADDR);
  assign m2_tick = (m2_div_reg >= (rate_double_reg ? M2_TICK_FAST : M2_TICK_SLOW));
  // Sixteen-times tick for mode 2; the >= keeps it safe when the rate bit changes mid-count
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      m2_div_reg <= 2'h0;
    end else if (m2_tick) begin
      m2_div_reg <= 2'h0;
    end else begin
      m2_div_reg <= m2_div_reg + 2'h1;
    end
  end
  assign tx_tick = (mode == MODE_UART9_FIXED) ? m2_tick : tx_ovf_tick;
  assign rx_tick = (mode == MODE_UART9_FIXED) ? m2_tick : rx_ovf_tick;
  assign tx_ti_set = (tx_state == TX_SHIFT) && tx_tick && (tx_os_reg == OS_LAST)
                     && (tx_left_reg == TX_STOP_NEXT);

  // Async transmitter; a new write restarts the frame rather than queueing it
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_state <= TX_IDLE;
      tx_shift_reg <= {11{IDLE_LINE}};
      tx_left_reg <= 4'h0;
      tx_os_reg <= 4'h0;
    end else if (wr_data && (mode != MODE_SHIFT)) begin
      tx_state <= TX_WAIT;
      tx_os_reg <= 4'h0;
      if (nine_bit) begin
        tx_left_reg <= FRAME_NINE;
        tx_shift_reg <= {STOP_BIT, ctrl_reg.tx_ninth_bit, reg_wdata, START_BIT};
      end else begin
        tx_left_reg <= FRAME_EIGHT;
        tx_shift_reg <= {STOP_BIT, STOP_BIT, reg_wdata, START_BIT};
      end
    end else begin
      case (tx_state)
        TX_IDLE: begin
          tx_os_reg <= 4'h0;
        end
        TX_WAIT: begin
          if (tx_tick) begin
            tx_state <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (tx_tick) begin
            if (tx_os_reg == OS_LAST) begin
              tx_os_reg <= 4'h0;
              if (tx_left_reg == TX_BIT_LAST) begin
                tx_state <= TX_IDLE;
              end else begin
                tx_shift_reg <= {IDLE_LINE, tx_shift_reg[10:1]};
                tx_left_reg <= tx_left_reg - 4'h1;
              end
            end else begin
              tx_os_reg <= tx_os_reg + 4'h1;
            end
          end
        end
        default: begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  // Mode 0 engine: last half-period of the eighth bit ends the transfer
  assign sy_done = (sy_state != SY_IDLE) && (sy_phase_reg == M0_PHASE_LAST)
                   && (sy_cnt_reg == M0_BIT_LAST);
  assign sy_frame = {rxd_in, sy_shift_reg[7:1]};
  // Transmit wins over a pending receive since both share the same two pins
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sy_state <= SY_IDLE;
      sy_shift_reg <= RESET_BYTE;
      sy_cnt_reg <= 4'h0;
      sy_phase_reg <= 1'b0;
    end else begin
      case (sy_state)
        SY_IDLE: begin
          sy_cnt_reg <= 4'h0;
          sy_phase_reg <= 1'b0;
          if (mode == MODE_SHIFT) begin
            if (wr_data) begin
              sy_state <= SY_TX;
              sy_shift_reg <= reg_wdata;
            end else if (ctrl_reg.rx_enable && !ctrl_reg.rx_done_flag) begin
              sy_state <= SY_RX;
            end
          end
        end
        SY_TX, SY_RX: begin
          sy_phase_reg <= ~sy_phase_reg;
          if (sy_phase_reg == M0_PHASE_LAST) begin
            if (sy_state == SY_RX) begin
              sy_shift_reg <= sy_frame;
            end else begin
              sy_shift_reg <= {IDLE_LINE, sy_shift_reg[7:1]};
            end
            sy_cnt_reg <= sy_cnt_reg + 4'h1;
            if (sy_cnt_reg == M0_BIT_LAST) begin
              sy_state <= SY_IDLE;
            end
          end
        end
        default: begin
          sy_state <= SY_IDLE;
        end
      endcase
    end
  end

  // Assembled async frame as it stands at the final sample
  assign rx_frame = {rxd_in, rx_shift_reg[9:1]};
  assign rx_final = (rx_state == RX_BITS) && rx_tick && (rx_os_reg == OS_LAST)
                    && (rx_cnt_reg == (nine_bit ? RX_LAST_NINE : RX_LAST_EIGHT));
  assign rx_ninth = nine_bit ? rx_frame[8] : rxd_in;
  assign rx_data = nine_bit ? rx_frame[7:0] : rx_frame[8:1];
  assign rx_accept = rx_final && !ctrl_reg.rx_done_flag && (rxd_in == STOP_BIT)
                     && (!ctrl_reg.multiprocessor_enable || rx_ninth);
  // Async receiver; once aligned to mid-start, every sixteenth tick lands mid-bit
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_state <= RX_IDLE;
      rx_shift_reg <= 10'h000;
      rx_os_reg <= 4'h0;
      rx_cnt_reg <= 4'h0;
      rx_prev_reg <= IDLE_LINE;
    end else begin
      rx_prev_reg <= rxd_in;
      case (rx_state)
        RX_IDLE: begin
          rx_os_reg <= 4'h0;
          rx_cnt_reg <= 4'h0;
          if ((mode != MODE_SHIFT) && ctrl_reg.rx_enable && rx_prev_reg && !rxd_in) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (rx_tick) begin
            rx_os_reg <= rx_os_reg + 4'h1;
            if (rx_os_reg == OS_MID) begin
              rx_os_reg <= 4'h0;
              if (rxd_in) begin
                rx_state <= RX_IDLE;
              end else begin
                rx_state <= RX_BITS;
              end
            end
          end
        end
        RX_BITS: begin
          if (rx_tick) begin
            rx_os_reg <= rx_os_reg + 4'h1;
            if (rx_os_reg == OS_LAST) begin
              rx_os_reg <= 4'h0;
              rx_shift_reg <= rx_frame;
              rx_cnt_reg <= rx_cnt_reg + 4'h1;
              if (rx_final) begin
                rx_state <= RX_IDLE;
              end
            end
          end
        end
        default: begin
          rx_state <= RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_buf_reg <= RESET_BYTE;
    end else if (rx_accept) begin
      rx_buf_reg <= rx_data;
    end else if (sy_done && (sy_state == SY_RX)) begin
      rx_buf_reg <= sy_frame;
    end
  end

  // Control next value; a hardware set beats a software clear in the same cycle
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = port_ctrl_t'(reg_wdata);
    end
    if (rx_accept) begin
      ctrl_next.rx_ninth_bit = rx_ninth;
    end
    if (tx_ti_set || (sy_done && (sy_state == SY_TX))) begin
      ctrl_next.tx_done_flag = 1'b1;
    end
    if (rx_accept || (sy_done && (sy_state == SY_RX))) begin
      ctrl_next.rx_done_flag = 1'b1;
    end
  end

  // Control register and rate-doubling bit
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= port_ctrl_t'(RESET_BYTE);
      rate_double_reg <= RESET_BIT;
    end else begin
      ctrl_reg <= ctrl_next;
      if (wr_rate) begin
        rate_double_reg <= reg_wdata[0];
      end
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= RESET_BYTE;
    end else if (!reg_rd) begin
      rdata_reg <= RESET_BYTE;
    end else if (reg_addr == DATA_ADDR) begin
      rdata_reg <= rx_buf_reg;
    end else if (reg_addr == CTRL_ADDR) begin
      rdata_reg <= ctrl_reg;
    end else if (reg_addr == RATE_ADDR) begin
      rdata_reg <= {7'h00, rate_double_reg};
    end else begin
      rdata_reg <= RESET_BYTE;
    end
  end
  assign reg_rdata = rdata_reg;

  // Pin drivers, registered so the pins never glitch; they lag state by one cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      txd_out <= IDLE_LINE;
      rxd_out <= IDLE_LINE;
      rxd_oe <= 1'b0;
    end else begin
      if (sy_state != SY_IDLE) begin
        txd_out <= sy_phase_reg;
      end else if (tx_state == TX_SHIFT) begin
        txd_out <= tx_shift_reg[0];
      end else begin
        txd_out <= IDLE_LINE;
      end
      rxd_out <= (sy_state == SY_TX) ? sy_shift_reg[0] : IDLE_LINE;
      rxd_oe <= (sy_state == SY_TX);
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  sequence m2_slow_gap;
    !m2_tick [*2] ##1 m2_tick;
  endsequence
  sequence m2_fast_gap;
    !m2_tick ##1 m2_tick;
  endsequence
  // A rate write inside the gap legally reshapes it, so such gaps are not judged
  chk_mode2_slow_rate: assert property (
    (m2_tick && !rate_double_reg && !wr_rate) ##1 !wr_rate [*2] |-> m2_slow_gap)
    else $error("mode 2 slow tick spacing wrong");
  chk_mode2_fast_rate: assert property (
    (m2_tick && rate_double_reg && !wr_rate) ##1 !wr_rate |-> m2_fast_gap)
    else $error("mode 2 fast tick spacing wrong");
  chk_rx_enable_gate: assert property (
    (rx_state == RX_IDLE) && !ctrl_reg.rx_enable |=> (rx_state == RX_IDLE))
    else $error("reception started while disabled");
  chk_tx_ninth_load: assert property (
    wr_data && nine_bit |=> (tx_shift_reg[9] == $past(ctrl_reg.tx_ninth_bit)) && !tx_shift_reg[0])
    else $error("ninth bit not loaded into transmit frame");
  chk_tx_start_write: assert property (
    wr_data && (mode != MODE_SHIFT) |=> (tx_state == TX_WAIT) ##1 (tx_state != TX_IDLE))
    else $error("write did not start async transmission");
  chk_tx_done_stop: assert property (
    tx_ti_set |=> ctrl_reg.tx_done_flag && tx_shift_reg[0] && (tx_left_reg == TX_BIT_LAST))
    else $error("transmit done not set at stop bit");
  chk_flags_sticky: assert property (
    ctrl_reg.rx_done_flag && !wr_ctrl |=> ctrl_reg.rx_done_flag)
    else $error("receive done cleared by hardware");
  chk_m0_rx_begin: assert property (
    (sy_state == SY_IDLE) && (mode == MODE_SHIFT) && !wr_data && ctrl_reg.rx_enable
    && !ctrl_reg.rx_done_flag |=> (sy_state == SY_RX))
    else $error("mode 0 reception did not begin");
  chk_m0_clock_out: assert property (
    (sy_state == SY_TX) ##1 (sy_state == SY_TX) |-> rxd_oe && (txd_out == $past(sy_phase_reg)))
    else $error("mode 0 clock or drive wrong");
  chk_start_glitch: assert property (
    (rx_state == RX_START) && rx_tick && (rx_os_reg == OS_MID) && rxd_in |=> (rx_state == RX_IDLE))
    else $error("start glitch not rejected");
  chk_frame_discard: assert property (
    rx_final && ctrl_reg.rx_done_flag && !wr_ctrl |=> $stable(rx_buf_reg))
    else $error("frame kept while receive done set");
  chk_rx_ninth_store: assert property (
    rx_accept |=> (ctrl_reg.rx_ninth_bit == $past(rx_ninth)) && ctrl_reg.rx_done_flag)
    else $error("ninth bit or done flag not stored");

endmodule

`default_nettype wire

// >>> tb/serial_peer.sv
`timescale 1ns/1ps
`default_nettype none

module serial_peer (
  input wire logic mclk,
  input wire logic txd,
  output var logic drv
);
  // Clock cycles per bit, set by the bench to match the port's rate
  int bit_cyc = 32;

  // Line idles high between frames
  initial drv = 1'b1;

  // Send one frame; a stop of 0 lets the bench make a framing fault
  // start 0, data LSB first, ninth only if use9, stop
  task automatic send(input logic [7:0] d, input logic nine, input logic use9,
                      input logic stop);
    logic [10:0] f;
    int n;
    f = use9 ? {stop, nine, d, 1'b0} : {1'b0, stop, d, 1'b0};
    n = use9 ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      drv <= f[i];
      repeat (bit_cyc) @(posedge mclk);
    end
    drv <= 1'b1;
  endtask

  // Short low pulse, far shorter than half a bit
  task automatic pulse(input int n);
    drv <= 1'b0;
    repeat (n) @(posedge mclk);
    drv <= 1'b1;
  endtask

  // Take one frame off the transmit pin, sampling each bit at its middle
  // frame shape as seen at the far end
  task automatic recv(input logic use9, output logic [8:0] d, output logic stop);
    int k;
    d = 'x;
    stop = 1'bx;
    k = 0;
    while (txd !== 1'b0 && k < 4000) begin
      @(negedge mclk);
      k++;
    end
    if (k < 4000) begin
      repeat (bit_cyc / 2) @(negedge mclk);
      for (int i = 0; i < (use9 ? 9 : 8); i++) begin
        repeat (bit_cyc) @(negedge mclk);
        d[i] = txd;
      end
      repeat (bit_cyc) @(negedge mclk);
      stop = txd;
    end
  endtask

  // Feed one byte to a mode 0 receive, LSB first, next bit after each rising shift clock
  // data follows the port's shift clock
  task automatic feed(input logic [7:0] d);
    logic p;
    int i;
    int k;
    p = txd;
    i = 0;
    k = 0;
    drv <= d[0];
    while (i < 8 && k < 200) begin
      @(negedge mclk);
      k++;
      if (txd === 1'b1 && p === 1'b0) begin
        i++;
        drv <= (i < 8) ? d[i] : 1'b1;
      end
      p = txd;
    end
  endtask
endmodule

`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import serial_port_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  addr_t reg_addr = 8'h00;
  byte_t reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tick = 1'b0;
  byte_t reg_rdata;
  logic rxd_out, rxd_oe, txd_out, peer_drv;
  wire logic rxd_in;
  int error_cnt = 0;
  int tests_run = 0;

  always #25 mclk = ~mclk;

  // Timer ticks every other clock, so 16 ticks make a 32-cycle bit
  always @(posedge mclk) tick <= sys_rst ? 1'b0 : ~tick;

  // Receive pin level: the port drives it only while shifting out in mode 0
  assign rxd_in = rxd_oe ? rxd_out : peer_drv;

  serial_port dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_ovf_tick(tick), .rx_ovf_tick(tick), .rxd_in(rxd_in), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .txd_out(txd_out));

  serial_peer peer (.mclk(mclk), .txd(txd_out), .drv(peer_drv));

  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask

  // One-cycle write strobe, launched just after an edge
  task automatic wr(input addr_t a, input byte_t d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe; take them mid-cycle
  task automatic rd(input addr_t a, output port_ctrl_t d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = port_ctrl_t'(reg_rdata);
  endtask

  function automatic byte_t cfg(logic [1:0] m, logic mpe, logic ren, logic tb8);
    return {m, mpe, ren, tb8, 3'h0};
  endfunction

  task automatic t_reset();
    port_ctrl_t r;
    rd(CTRL_ADDR, r);
    chk("ctrl reset", 9'h000, {1'b0, r});
    rd(DATA_ADDR, r);
    chk("data reset", 9'h000, {1'b0, r});
    rd(8'h55, r);
    chk("unmapped read", 9'h000, {1'b0, r});
  endtask

  task automatic t_m1_tx();
    port_ctrl_t r;
    logic [8:0] d;
    logic s;
    wr(CTRL_ADDR, cfg(MODE_UART8, 1'b0, 1'b0, 1'b0));
    wr(DATA_ADDR, 8'hA5);
    fork
      peer.recv(1'b0, d, s);
      begin
        repeat (150) @(posedge mclk);
        rd(CTRL_ADDR, r);
        chk("tx done mid frame", 9'h000, {8'h00, r.tx_done_flag});
      end
    join
    chk("m1 tx byte", 9'h0A5, {1'b0, d[7:0]});
    chk("m1 tx stop", 9'h001, {8'h00, s});
    rd(CTRL_ADDR, r);
    chk("m1 tx done", 9'h001, {8'h00, r.tx_done_flag});
  endtask

  task automatic t_m1_rx();
    port_ctrl_t r;
    wr(CTRL_ADDR, cfg(MODE_UART8, 1'b0, 1'b0, 1'b0));
    peer.send(8'h55, 1'b0, 1'b0, 1'b1);
    rd(CTRL_ADDR, r);
    chk("rx while disabled", 9'h000, {8'h00, r.rx_done_flag});
    wr(CTRL_ADDR, cfg(MODE_UART8, 1'b0, 1'b1, 1'b0));
    peer.pulse(5);
    repeat (64) @(posedge mclk);
    rd(CTRL_ADDR, r);
    chk("glitch start", 9'h000, {8'h00, r.rx_done_flag});
    peer.send(8'h3C, 1'b0, 1'b0, 1'b1);
    rd(CTRL_ADDR, r);
    chk("m1 rx done", 9'h003, {7'h00, r.rx_ninth_bit, r.rx_done_flag});
    rd(DATA_ADDR, r);
    chk("m1 rx byte", 9'h03C, {1'b0, r});
    peer.send(8'hC3, 1'b0, 1'b0, 1'b1);
    rd(DATA_ADDR, r);
    chk("overrun kept", 9'h03C, {1'b0, r});
    wr(CTRL_ADDR, cfg(MODE_UART8, 1'b0, 1'b1, 1'b0));
    peer.send(8'h81, 1'b0, 1'b0, 1'b0);
    rd(CTRL_ADDR, r);
    chk("bad stop flag", 9'h000, {8'h00, r.rx_done_flag});
    rd(DATA_ADDR, r);
    chk("bad stop data", 9'h03C, {1'b0, r});
  endtask

  task automatic t_m9();
    port_ctrl_t r;
    logic [8:0] d;
    logic s;
    wr(CTRL_ADDR, cfg(MODE_UART9_VAR, 1'b0, 1'b0, 1'b1));
    wr(DATA_ADDR, 8'h6E);
    peer.recv(1'b1, d, s);
    chk("m3 tx frame", 9'h16E, d);
    chk("m3 tx stop", 9'h001, {8'h00, s});
    // Fixed rate: 64 clocks per bit, 32 with doubling
    for (int dbl = 0; dbl < 2; dbl++) begin
      wr(RATE_ADDR, byte_t'(dbl));
      wr(CTRL_ADDR, cfg(MODE_UART9_FIXED, 1'b0, 1'b0, dbl[0]));
      peer.bit_cyc = (dbl == 1) ? MODE2_DIV_FAST : MODE2_DIV;
      wr(DATA_ADDR, 8'hC9);
      peer.recv(1'b1, d, s);
      chk("m2 tx frame", {dbl[0], 8'hC9}, d);
      chk("m2 tx stop", 9'h001, {8'h00, s});
    end
    peer.bit_cyc = 32;
    wr(RATE_ADDR, 8'h00);
    wr(CTRL_ADDR, cfg(MODE_UART9_VAR, 1'b1, 1'b1, 1'b0));
    peer.send(8'h11, 1'b0, 1'b1, 1'b1);
    rd(CTRL_ADDR, r);
    chk("mp drop", 9'h000, {8'h00, r.rx_done_flag});
    peer.send(8'h22, 1'b1, 1'b1, 1'b1);
    rd(CTRL_ADDR, r);
    chk("mp accept", 9'h003, {7'h00, r.rx_ninth_bit, r.rx_done_flag});
    wr(CTRL_ADDR, cfg(MODE_UART9_VAR, 1'b0, 1'b1, 1'b0));
    peer.send(8'h33, 1'b0, 1'b1, 1'b1);
    rd(CTRL_ADDR, r);
    chk("m3 ninth 0", 9'h001, {7'h00, r.rx_ninth_bit, r.rx_done_flag});
    rd(DATA_ADDR, r);
    chk("m3 rx byte", 9'h033, {1'b0, r});
  endtask

  task automatic t_m0();
    port_ctrl_t r;
    logic p;
    logic [7:0] b;
    int k;
    p = 1'b1;
    b = 8'h00;
    k = 0;
    wr(CTRL_ADDR, cfg(MODE_SHIFT, 1'b0, 1'b0, 1'b0));
    wr(DATA_ADDR, 8'h96);
    // Take the data bit at each rising edge of the shift clock
    repeat (60) begin
      @(negedge mclk);
      if (txd_out === 1'b1 && p === 1'b0 && k < 8) begin
        b[k] = rxd_out;
        k++;
        chk("m0 drive enable", 9'h001, {8'h00, rxd_oe});
      end
      p = txd_out;
    end
    chk("m0 tx byte", 9'h096, {1'b0, b});
    chk("m0 clock count", 9'h008, 9'(k));
    rd(CTRL_ADDR, r);
    chk("m0 tx done", 9'h001, {8'h00, r.tx_done_flag});
    // The far end presents a mixed pattern so that bit order and sampling point show
    fork
      peer.feed(8'hA3);
      wr(CTRL_ADDR, cfg(MODE_SHIFT, 1'b0, 1'b1, 1'b0));
    join
    repeat (8) @(posedge mclk);
    rd(CTRL_ADDR, r);
    chk("m0 rx done", 9'h001, {8'h00, r.rx_done_flag});
    rd(DATA_ADDR, r);
    chk("m0 rx byte", 9'h0A3, {1'b0, r});
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_m1_tx();
    t_m1_rx();
    t_m9();
    t_m0();
    summarize();
  end

  // Watchdog: all frames together take well under this span
  initial begin
    repeat (40000) @(posedge mclk);
    $display("[ERR] watchdog expected finish seen hang");
    error_cnt++;
    summarize();
  end
endmodule

`default_nettype wire
